/* File: hdl/sfr_defines.vh */
// Constants for the status and fault reporting block.
// Assumes a single 200 MHz system clock; included by bare name.
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH

// Bit positions shared by live, sticky, mask and fault registers
`define SFR_BIT_VREG      0
`define SFR_BIT_IREG      1
`define SFR_BIT_RANGE     2
`define SFR_BIT_OVER_V    3
`define SFR_BIT_THERMAL   4
`define SFR_BIT_MAINS     5
`define SFR_BIT_SHUTBACK  6
`define SFR_BIT_CMD_ERR   7
`define SFR_BIT_EXT_BLOCK 8
`define SFR_STAT_W        9

// Poll byte bit positions
`define SFR_POLL_FAULT    0
`define SFR_POLL_PWRUP    1
`define SFR_POLL_IDLE     4
`define SFR_POLL_CMDERR   5
`define SFR_POLL_SRVREQ   6

// Reset values
`define SFR_MASK_RST      9'h000
`define SFR_STAT_RST      9'h000
`define SFR_POLL_RST      8'h02
// Mode bits held off the fault register during settling
`define SFR_SETTLE_BITS   9'h007

// Timing: settling delay in ms, clock period and one ms in ns
`define SFR_DELAY_DEF_MS  15'h01F4
`define SFR_DELAY_MAX_MS  15'h7CFF
`define SFR_MS_NS         1000000
`define SFR_CLK_NS        5

`endif

/* File: hdl/sfr_sync3.v */
// Three-stage input synchroniser for pin-level inputs.
// Assumes inputs are asynchronous to clk; output follows once
// stages two and three agree, so a lone glitch is filtered.
module sfr_sync3 #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         ce,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;

    // First stage feeds only the second stage
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else if (ce) begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout);
        end
    end

endmodule // sfr_sync3

/* File: hdl/sfr_status_fault.v */
// Status and fault reporting of a programmable supply: live, sticky,
// mask and fault registers, settling delay and the poll status byte.
// Assumes the command parser runs on clk and issues one-cycle query
// and command strobes; condition pins are asynchronous.
//
// Notes on behaviour
// - Sticky copy latches conditions until read
// - Sticky read reports, then reloads live status
// - Fault and mask share live bit layout
// - Only masked live bits reach fault register
// - Fault bits set on rising edges only
// - Select-event-sources command sets named mask bits
// - Fault read returns contents, then clears all but same-cycle edges
// - Registers reported as binary weight sums
// - Poll byte: fault, power-up, idle, error, service
// - Command error set on invalid, cleared by query
// - Fault summary is OR; cleared by fault read
// - External block holds summary through fault read
// - Idle bit low while commands are processing
// - Power-up set at power-on; cleared by reset commands
// - Service request bit cleared by serial poll
// - Settling delay hides mode edges from faults
// - Live bits: vreg,ireg,range,overv,therm,mains,shut,err,block
// - Live bits follow conditions continuously
// - Service request raised when summary rises, enabled
// - Settling delay default 500 ms, 0..31999 ms
`include "sfr_defines.vh"

module sfr_status_fault #(
    parameter CYC_PER_MS = `SFR_MS_NS / `SFR_CLK_NS,
    parameter PW         = 18
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        ce,
    // Condition pins, asynchronous
    input  wire        voltage_regulation_mode,
    input  wire        current_regulation_mode,
    input  wire        out_of_range_mode,
    input  wire        excess_voltage_trip,
    input  wire        thermal_trip,
    input  wire        mains_dropout,
    input  wire        current_limit_shutback,
    input  wire        external_block_line,
    // Parser strobes and levels, same clock
    input  wire        live_status_read,
    input  wire        sticky_status_read,
    input  wire        latched_event_read,
    input  wire        error_code_query,
    input  wire        select_event_sources,
    input  wire [8:0]  event_sources,
    input  wire        device_reset_command,
    input  wire        bus_device_clear,
    input  wire        invalid_command,
    input  wire        cmd_busy,
    input  wire        service_req_on,
    input  wire        service_req_off,
    input  wire        settle_delay_command,
    input  wire [14:0] settle_delay_ms,
    input  wire        settle_start,
    input  wire        serial_poll,
    // Answers
    output reg  [8:0]  read_data_r,
    output reg         read_valid_r,
    output reg  [8:0]  live_status_r,
    output reg  [8:0]  event_enable_mask_r,
    output reg  [7:0]  poll_status_byte_r,
    output reg         service_request_r,
    output reg         settling_r
);

    wire [7:0] pins_sync;
    reg  [8:0] sticky_status_r;
    reg  [8:0] latched_events_r;
    reg  [8:0] live_prev_r;
    reg        srq_enable_r;
    reg [14:0] settle_ms_r;
    reg [14:0] ms_left_r;
    reg [PW-1:0] presc_r;

    reg  [8:0] live_nxt;
    reg  [8:0] sticky_nxt;
    reg  [8:0] rise_nxt;
    reg  [8:0] latched_nxt;
    reg  [8:0] mask_nxt;
    reg  [7:0] poll_nxt;
    reg        fault_sum_nxt;
    reg        err_nxt;
    reg        pwrup_nxt;
    reg        srq_nxt;
    reg        srq_en_nxt;
    reg [14:0] settle_ms_nxt;
    reg [14:0] ms_left_nxt;
    reg [PW-1:0] presc_nxt;
    reg  [8:0] read_data_nxt;
    reg        read_valid_nxt;

    // Prescaler reload, cut to the counter width on purpose
    localparam integer  PRESC_INT = CYC_PER_MS - 1;
    localparam [PW-1:0] PRESC_TOP = PRESC_INT[PW-1:0];

    // Timing of the paths through this block
    //
    // Condition pins
    //   A pin change is taken into s1 on the first edge, s2 on the
    //   second and s3 on the third. The filtered copy follows on the
    //   edge after s2 and s3 agree, so a one-cycle glitch on a pin is
    //   dropped. Live status then follows one edge later, and so do
    //   the sticky copy and the fault register, since both are fed
    //   from the same next-state value as live status.
    //
    // Live status
    //   Bits 0..6 and 8 are the filtered pins. Bit 7 is the command
    //   error flag of the poll byte, taken from the registered flag,
    //   so it lags the poll bit by one cycle. A host that reads live
    //   status in the cycle right after an invalid command can miss
    //   the error bit; the parser never answers that quickly.
    //
    // Sticky copy
    //   Every cycle ORs in the live value. A sticky read answers with
    //   the old copy and reloads it with live status, so a condition
    //   that is still true shows again on the next read.
    //
    // Fault register
    //   Only rising edges of enabled live bits are recorded. The mask
    //   can only gain bits; a device reset leaves it as it was, so a
    //   host that wants a clean slate must reset the whole block.
    //   A fault read clears the register, but an edge found in the
    //   same cycle is kept, otherwise a fault arriving just as the
    //   host reads would be lost for good.
    //
    // Settling
    //   A settle start loads the millisecond count. While it runs,
    //   the three regulation mode bits cannot reach the fault
    //   register. A mode that is still true when the count expires
    //   is not recorded later either, because only edges count; the
    //   host sees it in live status instead.
    //   A delay of zero gives no hold-off at all.
    //   The count is clamped to the largest legal value so that an
    //   oversized request cannot wrap into a short delay.
    //
    // Poll byte
    //   The fault summary is the OR of the fault register and of any
    //   edge about to land, so it rises in the same cycle as the
    //   fault bit. A fault read clears it unless the external block
    //   line is high; while blocked the host must read again once the
    //   line has dropped.
    //   A service request is raised only on a rise of the summary,
    //   never on its level, so one fault gives one request.
    //   An invalid command beats a same-cycle error query: losing an
    //   error report is worse than reporting one twice.
    //
    // Query answers
    //   One answer per strobe, one cycle later. If strobes coincide,
    //   sticky wins over fault, and fault over live. Read data holds
    //   its value until the next query.
    //
    // Clock enable
    //   With ce low every register holds, the synchroniser included,
    //   so pin changes are not seen until ce returns.

    // Condition pins cross into clk through three stages
    sfr_sync3 #(
        .W (8)
    ) u_pin_sync (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .din   ({external_block_line, current_limit_shutback,
                 mains_dropout, thermal_trip, excess_voltage_trip,
                 out_of_range_mode, current_regulation_mode,
                 voltage_regulation_mode}),
        .dout  (pins_sync)
    );

    // Live status mirrors conditions; the error bit is the poll flag
    always @* begin
        live_nxt = {pins_sync[7], poll_status_byte_r[`SFR_POLL_CMDERR],
                    pins_sync[6:0]};
    end

    // Sticky copy: OR in live each cycle, reload on its read
    always @* begin
        if (sticky_status_read) begin
            sticky_nxt = live_nxt;
        end else begin
            sticky_nxt = sticky_status_r | live_nxt;
        end
    end

    // Mask write sets named bits; earlier selections remain
    always @* begin
        mask_nxt = event_enable_mask_r;
        if (select_event_sources) begin
            mask_nxt = event_enable_mask_r | event_sources;
        end
    end

    // Rising edges of enabled live bits; mode bits held off while
    // settling so brief range excursions are not recorded
    always @* begin
        rise_nxt = live_nxt & ~live_prev_r;
        rise_nxt = rise_nxt & event_enable_mask_r;
        if (settling_r) begin
            rise_nxt = rise_nxt & ~`SFR_SETTLE_BITS;
        end
    end

    // Fault read clears, but a same-cycle edge still lands
    always @* begin
        if (latched_event_read) begin
            latched_nxt = rise_nxt;
        end else begin
            latched_nxt = latched_events_r | rise_nxt;
        end
    end

    // Poll byte flags
    always @* begin
        fault_sum_nxt = poll_status_byte_r[`SFR_POLL_FAULT]
                        | (|latched_events_r) | (|rise_nxt);
        if (latched_event_read && !pins_sync[7]) begin
            fault_sum_nxt = |rise_nxt;
        end
        err_nxt = poll_status_byte_r[`SFR_POLL_CMDERR];
        if (error_code_query) begin
            err_nxt = 1'b0;
        end
        if (invalid_command) begin
            err_nxt = 1'b1;
        end
        pwrup_nxt = poll_status_byte_r[`SFR_POLL_PWRUP];
        if (device_reset_command || bus_device_clear) begin
            pwrup_nxt = 1'b0;
        end
        srq_en_nxt = srq_enable_r;
        if (service_req_on) begin
            srq_en_nxt = 1'b1;
        end
        if (service_req_off) begin
            srq_en_nxt = 1'b0;
        end
        // Request on summary rise wins over a same-cycle poll clear
        srq_nxt = poll_status_byte_r[`SFR_POLL_SRVREQ];
        if (serial_poll) begin
            srq_nxt = 1'b0;
        end
        if (fault_sum_nxt && !poll_status_byte_r[`SFR_POLL_FAULT]
            && srq_enable_r) begin
            srq_nxt = 1'b1;
        end
        poll_nxt = 8'h00;
        poll_nxt[`SFR_POLL_FAULT]  = fault_sum_nxt;
        poll_nxt[`SFR_POLL_PWRUP]  = pwrup_nxt;
        poll_nxt[`SFR_POLL_IDLE]   = ~cmd_busy;
        poll_nxt[`SFR_POLL_CMDERR] = err_nxt;
        poll_nxt[`SFR_POLL_SRVREQ] = srq_nxt;
    end

    // Settling delay: millisecond count driven by a prescaler
    always @* begin
        settle_ms_nxt = settle_ms_r;
        if (settle_delay_command) begin
            if (settle_delay_ms > `SFR_DELAY_MAX_MS) begin
                settle_ms_nxt = `SFR_DELAY_MAX_MS;
            end else begin
                settle_ms_nxt = settle_delay_ms;
            end
        end
        ms_left_nxt = ms_left_r;
        presc_nxt   = presc_r;
        if (settle_start) begin
            ms_left_nxt = settle_ms_r;
            presc_nxt   = PRESC_TOP;
        end else if (ms_left_r != 15'h0000) begin
            if (presc_r == {PW{1'b0}}) begin
                presc_nxt   = PRESC_TOP;
                ms_left_nxt = ms_left_r - 15'h0001;
            end else begin
                presc_nxt = presc_r - {{(PW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Query answers: value is the binary weight sum of set bits
    always @* begin
        read_valid_nxt = 1'b1;
        read_data_nxt  = read_data_r;
        if (sticky_status_read) begin
            read_data_nxt = sticky_status_r;
        end else if (latched_event_read) begin
            read_data_nxt = latched_events_r;
        end else if (live_status_read) begin
            read_data_nxt = live_status_r;
        end else begin
            read_valid_nxt = 1'b0;
        end
    end

    // State registers; clock enable freezes everything
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            live_status_r       <= `SFR_STAT_RST;
            live_prev_r         <= `SFR_STAT_RST;
            sticky_status_r     <= `SFR_STAT_RST;
            latched_events_r    <= `SFR_STAT_RST;
            event_enable_mask_r <= `SFR_MASK_RST;
            poll_status_byte_r  <= `SFR_POLL_RST;
            service_request_r   <= 1'b0;
            srq_enable_r        <= 1'b0;
            settle_ms_r         <= `SFR_DELAY_DEF_MS;
            ms_left_r           <= 15'h0000;
            presc_r             <= {PW{1'b0}};
            settling_r          <= 1'b0;
            read_data_r         <= `SFR_STAT_RST;
            read_valid_r        <= 1'b0;
        end else if (ce) begin
            live_status_r       <= live_nxt;
            live_prev_r         <= live_nxt;
            sticky_status_r     <= sticky_nxt;
            latched_events_r    <= latched_nxt;
            event_enable_mask_r <= mask_nxt;
            poll_status_byte_r  <= poll_nxt;
            service_request_r   <= srq_nxt;
            srq_enable_r        <= srq_en_nxt;
            settle_ms_r         <= settle_ms_nxt;
            ms_left_r           <= ms_left_nxt;
            presc_r             <= presc_nxt;
            settling_r          <= (ms_left_nxt != 15'h0000);
            read_data_r         <= read_data_nxt;
            read_valid_r        <= read_valid_nxt;
        end
    end

endmodule // sfr_status_fault

/* File: tb/sfr_status_fault_props.sv */
// Checker for the status and fault block, bound to its top module.
// Assumes parser strobes are one-cycle pulses on the same clock.
module sfr_sf_props (
    input wire       clk, reset, ce, cmd_busy, invalid_command,
    input wire       error_code_query, device_reset_command,
    input wire       bus_device_clear, select_event_sources,
    input wire       live_status_read, sticky_status_read,
    input wire       latched_event_read, read_valid_r,
    input wire       service_request_r,
    input wire [8:0] event_sources, event_enable_mask_r, live_status_r,
    input wire [7:0] poll_status_byte_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire [7:0] p = poll_status_byte_r;
    wire       q = live_status_read | sticky_status_read | latched_event_read;

    // Answers come one cycle after a query; flags one cycle after a strobe
    q_answer_a: assert property (ce && q |=> read_valid_r)
        else $error("query not answered");
    mask_set_a: assert property (ce && select_event_sources |=>
        (event_enable_mask_r & $past(event_sources)) == $past(event_sources))
        else $error("named mask bits not set");
    mask_hold_a: assert property (!select_event_sources |=>
        $stable(event_enable_mask_r)) else $error("mask changed unasked");
    poll_spare_a: assert property ({p[7], p[3:2]} == 3'h0)
        else $error("unused poll bits set");
    srq_mirror_a: assert property (service_request_r == p[6])
        else $error("service request and poll bit differ");
    err_set_a: assert property (ce && invalid_command |=>
        p[5] ##1 live_status_r[7]) else $error("command error not set");
    err_clear_a: assert property (ce && error_code_query &&
        !invalid_command |=> !p[5]) else $error("command error kept");
    pwr_clear_a: assert property (ce && (device_reset_command ||
        bus_device_clear) |=> !p[1]) else $error("power-up flag kept");
    idle_track_a: assert property (ce && !reset |=>
        p[4] == !$past(cmd_busy))
        else $error("idle bit wrong");
    // Block line must stay high across the read for the hold to apply
    block_hold_a: assert property (ce && latched_event_read && p[0] &&
        live_status_r[8] ##1 live_status_r[8] |-> p[0])
        else $error("summary cleared while blocked");
endmodule // sfr_sf_props

bind sfr_status_fault sfr_sf_props sfr_sf_props_i (.*);

/* File: tb/sfr_host_model.sv */
// Host controller model: one-cycle query and command strobes.
// Assumes the block answers a query in the cycle after taking it.
module sfr_host_model (
    input  wire         clk,
    input  wire  [8:0]  read_data_r,
    input  wire         read_valid_r,
    output logic [12:0] strb,
    output logic [8:0]  src
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        strb = 13'h0000;
        src = 9'h000;
    end

    // One strobe for one clock; source bits held until the next one
    task automatic strobe(input int i, input logic [8:0] m);
        @(posedge clk);
        src <= m;
        strb[i] <= 1'b1;
        @(posedge clk);
        strb <= 13'h0000;
        #1;
    endtask

    // A missing answer reads back as unknown so it cannot match
    task automatic rd(input int i, output logic [8:0] d);
        strobe(i, 9'h000);
        d = read_valid_r ? read_data_r : 9'hxxx;
    endtask
endmodule // sfr_host_model

/* File: tb/sfr_status_fault_tb.sv */
// Self-checking bench for the status and fault block.
// Assumes the host model drives strobes; condition pins driven here.
module sfr_status_fault_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        cmd_busy = 1'b0;
    logic [7:0]  pins = 8'h00;
    logic [14:0] dly = 15'h01F4;
    logic [8:0]  d;
    wire  [12:0] s;
    wire  [8:0]  src, rdat, live, mask;
    wire  [7:0]  poll;
    wire         rv, srq, settling;
    int          miscompares = 0;
    int          tests_run = 0;

    always #2.5 clk = ~clk;

    // Four cycles per ms keeps settling runs short
    sfr_status_fault #(.CYC_PER_MS(4)) sfr_status_fault_i (
        .clk(clk), .reset(reset), .ce(1'b1),
        .voltage_regulation_mode(pins[0]),
        .current_regulation_mode(pins[1]), .out_of_range_mode(pins[2]),
        .excess_voltage_trip(pins[3]), .thermal_trip(pins[4]),
        .mains_dropout(pins[5]), .current_limit_shutback(pins[6]),
        .external_block_line(pins[7]), .live_status_read(s[0]),
        .sticky_status_read(s[1]), .latched_event_read(s[2]),
        .error_code_query(s[3]), .select_event_sources(s[4]),
        .event_sources(src), .device_reset_command(s[5]),
        .bus_device_clear(s[6]), .invalid_command(s[7]),
        .cmd_busy(cmd_busy), .service_req_on(s[8]),
        .service_req_off(s[9]), .settle_delay_command(s[10]),
        .settle_delay_ms(dly), .settle_start(s[11]), .serial_poll(s[12]),
        .read_data_r(rdat), .read_valid_r(rv), .live_status_r(live),
        .event_enable_mask_r(mask), .poll_status_byte_r(poll),
        .service_request_r(srq), .settling_r(settling));
    sfr_host_model sfr_host_model_i (.clk(clk), .read_data_r(rdat),
        .read_valid_r(rv), .strb(s), .src(src));

    task automatic chk(input string n, input logic [8:0] e, v);
        tests_run++;
        if (v !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic pb(input int k, input logic e);
        chk("poll bit", {8'h00, e}, {8'h00, poll[k]});
    endtask
    task automatic st(input int i, input logic [8:0] m = 9'h000);
        sfr_host_model_i.strobe(i, m);
    endtask
    task automatic rd(input int i);
        sfr_host_model_i.rd(i, d);
    endtask
    // Pins pass a synchroniser, so allow it time to settle
    task automatic setp(input logic [7:0] v);
        @(posedge clk);
        pins <= v;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_fault;
        st(4, 9'h118);
        chk("mask", 9'h118, mask);
        setp(8'h30);
        rd(0);
        chk("live", 9'h030, d);
        pb(0, 1'b1);
        rd(2);
        chk("fault", 9'h010, d);
        pb(0, 1'b0);
        rd(2);
        chk("fault level", 9'h000, d);
        setp(8'h00);
    endtask
    task automatic t_sticky;
        rd(1);
        setp(8'h20);
        setp(8'h00);
        chk("live", 9'h000, live);
        rd(1);
        chk("sticky", 9'h020, d);
        rd(1);
        chk("sticky reload", 9'h000, d);
    endtask
    task automatic t_block;
        setp(8'h80);
        rd(2);
        chk("fault", 9'h100, d);
        pb(0, 1'b1);
        setp(8'h00);
        rd(2);
        pb(0, 1'b0);
    endtask
    task automatic t_flags;
        st(7);
        @(posedge clk);
        #1;
        chk("error", 9'h003, {7'h00, live[7], poll[5]});
        st(3);
        pb(5, 1'b0);
        st(8);
        setp(8'h08);
        chk("request", 9'h003, {7'h00, srq, poll[6]});
        st(12);
        pb(6, 1'b0);
        rd(2);
        st(9);
        setp(8'h00);
        @(posedge clk);
        cmd_busy <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        pb(4, 1'b0);
    endtask
    task automatic t_settle;
        @(posedge clk);
        cmd_busy <= 1'b0;
        dly <= 15'h0005;
        st(4, 9'h004);
        st(10);
        st(11);
        chk("settling", 9'h001, {8'h00, settling});
        setp(8'h04);
        rd(2);
        chk("fault held off", 9'h000, d);
        for (int i = 0; i < 200 && settling; i++)
            @(posedge clk);
        if (settling) begin
            miscompares++;
            print_verdict;
        end
        setp(8'h00);
        setp(8'h04);
        rd(2);
        chk("fault", 9'h004, d);
        pb(4, 1'b1);
    endtask
    task automatic t_pwr;
        st(5);
        pb(1, 1'b0);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        pb(1, 1'b1);
        st(6);
        pb(1, 1'b0);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("poll", 9'h012, {1'b0, poll});
        chk("mask", 9'h000, mask);
        t_fault;
        t_sticky;
        t_block;
        t_flags;
        t_settle;
        t_pwr;
        print_verdict;
    end
endmodule // sfr_status_fault_tb
